/* File: ldoctl_regs.vh */
// register offsets, field positions and voltage code constants for the regulator control bank
`ifndef LDOCTL_REGS_VH
`define LDOCTL_REGS_VH

`define LDOCTL_ADDR_SEVEN 8'h1e
`define LDOCTL_ADDR_EIGHT 8'h1f
`define LDOCTL_ADDR_NINE 8'h20
`define LDOCTL_ADDR_TEN 8'h21

`define LDOCTL_CHAN_SEVEN 2'h0
`define LDOCTL_CHAN_EIGHT 2'h1
`define LDOCTL_CHAN_NINE 2'h2
`define LDOCTL_CHAN_TEN 2'h3

`define LDOCTL_EN_BIT 7
`define LDOCTL_ECO_BIT 6
`define LDOCTL_SEL_MSB 5
`define LDOCTL_SEL_LSB 0

`define LDOCTL_ECO_RESET 1'h0
`define LDOCTL_CTL_RESET 8'h00
`define LDOCTL_RDATA_UNMAPPED 8'h00

// millivolt figures: 800, 25, 1600, 50, 3100, 3200, 3300
`define LDOCTL_LOW_BASE_MV 12'h0320
`define LDOCTL_LOW_STEP_MV 12'h0019
`define LDOCTL_HIGH_BASE_MV 12'h0640
`define LDOCTL_HIGH_STEP_MV 12'h0032
`define LDOCTL_TOP_A_MV 12'h0c1c
`define LDOCTL_TOP_B_MV 12'h0c80
`define LDOCTL_TOP_C_MV 12'h0ce4

`define LDOCTL_CODE_TOP_A 6'h3d
`define LDOCTL_CODE_TOP_B 6'h3e
`define LDOCTL_CODE_TOP_C 6'h3f

`endif

/* File: ldoctl_regs.v */
// control register bank for regulators seven to ten, with voltage code decoding
`timescale 1ns/1ns
`include "ldoctl_regs.vh"

module ldoctl_regs (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // register access port from the serial host port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    // factory defaults, channel 0 is regulator seven
    input wire [3:0] otp_enable,
    input wire [23:0] otp_sel,
    output reg defaults_loaded,
    // forced-off requests per channel
    input wire [3:0] set_off,
    // regulator controls
    output reg [3:0] ldo_on,
    output reg [3:0] ldo_eco,
    output reg [23:0] ldo_sel,
    output reg [47:0] ldo_mv,
    // restricted-range decode for the upper-range-only regulators
    input wire [5:0] upper_sel,
    output reg [5:0] upper_sel_eff,
    output reg [11:0] upper_mv
);

    ////////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // returns {hit, channel}
    function [2:0] chan_decode;
        input [7:0] a;
        begin
            if (a == `LDOCTL_ADDR_SEVEN) begin
                chan_decode = {1'b1, `LDOCTL_CHAN_SEVEN};
            end else if (a == `LDOCTL_ADDR_EIGHT) begin
                chan_decode = {1'b1, `LDOCTL_CHAN_EIGHT};
            end else if (a == `LDOCTL_ADDR_NINE) begin
                chan_decode = {1'b1, `LDOCTL_CHAN_NINE};
            end else if (a == `LDOCTL_ADDR_TEN) begin
                chan_decode = {1'b1, `LDOCTL_CHAN_TEN};
            end else begin
                chan_decode = 3'h0;
            end
        end
    endfunction

    function [11:0] code_to_mv;
        input [5:0] s;
        begin
            if (!s[`LDOCTL_SEL_MSB]) begin
                code_to_mv = `LDOCTL_LOW_BASE_MV + {7'h00, s[4:0]} * `LDOCTL_LOW_STEP_MV;
            end else if (s == `LDOCTL_CODE_TOP_A) begin
                code_to_mv = `LDOCTL_TOP_A_MV;
            end else if (s == `LDOCTL_CODE_TOP_B) begin
                code_to_mv = `LDOCTL_TOP_B_MV;
            end else if (s == `LDOCTL_CODE_TOP_C) begin
                code_to_mv = `LDOCTL_TOP_C_MV;
            end else begin
                code_to_mv = `LDOCTL_HIGH_BASE_MV + {7'h00, s[4:0]} * `LDOCTL_HIGH_STEP_MV;
            end
        end
    endfunction

    // true when a decoded offset belongs to channel c
    // only the two low bits of c matter, channels are 0..3
    function chan_hit;
        input [2:0] d;
        input [31:0] c;
        begin
            chan_hit = d[2] && (d[1:0] == c[1:0]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // register storage

    reg [7:0] ctl [0:3];
    wire [2:0] wr_dec;
    wire [2:0] rd_dec;
    wire [3:0] wr_hit;
    wire [3:0] next_on;
    wire [3:0] next_eco;
    wire [23:0] next_sel;
    wire [47:0] next_mv;
    integer n;

    assign wr_dec = chan_decode(reg_addr);
    assign rd_dec = wr_dec;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_chan
            // offsets never overlap, so at most one strobe is high
            assign wr_hit[i] = reg_wr & chan_hit(wr_dec, i);
            assign next_on[i] = ctl[i][`LDOCTL_EN_BIT] & ~set_off[i];
            assign next_eco[i] = ctl[i][`LDOCTL_ECO_BIT];
            assign next_sel[i*6 +: 6] = ctl[i][`LDOCTL_SEL_MSB:`LDOCTL_SEL_LSB];
            assign next_mv[i*12 +: 12] = code_to_mv(ctl[i][`LDOCTL_SEL_MSB:`LDOCTL_SEL_LSB]);
        end
    endgenerate

    // defaults land on the first edge after release; writes then are dropped
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (n = 0; n < 4; n = n + 1) begin
                ctl[n] <= `LDOCTL_CTL_RESET;
            end
        end else if (!defaults_loaded) begin
            for (n = 0; n < 4; n = n + 1) begin
                ctl[n] <= {otp_enable[n], `LDOCTL_ECO_RESET, otp_sel[n*6 +: 6]};
            end
        end else begin
            for (n = 0; n < 4; n = n + 1) begin
                if (wr_hit[n]) begin
                    ctl[n] <= reg_wdata;
                end
            end
        end
    end

    // outputs registered so the regulators never see a decode glitch
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ldo_on <= 4'h0;
        end else begin
            ldo_on <= next_on;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ldo_eco <= 4'h0;
        end else begin
            ldo_eco <= next_eco;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ldo_sel <= 24'h00_0000;
        end else begin
            ldo_sel <= next_sel;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ldo_mv <= 48'h0000_0000_0000;
        end else begin
            ldo_mv <= next_mv;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // default load and readback

    // load takes one clock after release so no async path samples the defaults
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            defaults_loaded <= 1'b0;
        end else begin
            defaults_loaded <= 1'b1;
        end
    end

    // unmapped offsets read as zero so software always sees a defined byte
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= `LDOCTL_RDATA_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd && rd_dec[2]) begin
                reg_rdata <= ctl[rd_dec[1:0]];
            end else if (reg_rd) begin
                reg_rdata <= `LDOCTL_RDATA_UNMAPPED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // restricted upper-range decode
    // limitation: upper_sel[5] is ignored, the low range cannot be reached

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            upper_sel_eff <= 6'h00;
            upper_mv <= 12'h000;
        end else begin
            // top bit forced so only the upper range is reachable
            upper_sel_eff <= {1'b1, upper_sel[4:0]};
            // restricted table equals the general upper half
            upper_mv <= code_to_mv({1'b1, upper_sel[4:0]});
        end
    end

endmodule

/* File: ldoctl_regs_properties.sv */
// assertions on the regulator control bank ports
`timescale 1ns/1ns
module ldoctl_chk (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // host port and regulator side
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire defaults_loaded,
    input wire [3:0] otp_enable,
    input wire [3:0] set_off,
    input wire [3:0] ldo_on,
    input wire [3:0] ldo_eco,
    input wire [23:0] ldo_sel,
    input wire [47:0] ldo_mv,
    input wire [5:0] upper_sel,
    input wire [5:0] upper_sel_eff,
    input wire [11:0] upper_mv
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    function automatic [11:0] mv(input [5:0] s);
        mv = s < 32 ? 800 + 25 * s : s < 61 ? 1600 + 50 * (s - 32) : 3100 + 100 * (s - 61);
    endfunction
    //////////////////////////////
    chk_forced_off: assert property (set_off[0] |=> !ldo_on[0])
        else $error("forced off ignored");
    chk_defaults_load: assert property ($rose(defaults_loaded) |=>
        ldo_on == (otp_enable & ~$past(set_off))) else $error("bad default enable");
    chk_sel_write: assert property (reg_wr && defaults_loaded && reg_addr == 8'h20 |->
        ##2 ldo_sel[17:12] == $past(reg_wdata[5:0], 2)) else $error("select not written");
    // outputs decode the reset control bytes (ldo_mv reads 800) until the cycle after the load
    chk_general_mv: assert property (defaults_loaded && $past(defaults_loaded) |->
        ldo_mv[11:0] == mv(ldo_sel[5:0]) && ldo_mv[47:36] == mv(ldo_sel[23:18]))
        else $error("general decode wrong");
    chk_upper_mv: assert property (defaults_loaded |-> upper_mv == mv(upper_sel_eff))
        else $error("restricted decode wrong");
    chk_top_bit: assert property (defaults_loaded |->
        upper_sel_eff == {1'b1, $past(upper_sel[4:0])}) else $error("top bit not forced");
    chk_eco_reset: assert property ($rose(defaults_loaded) |=> ldo_eco == 4'h0)
        else $error("light load not cleared");
    cover property ($rose(defaults_loaded));
    cover property (reg_wr && reg_addr == 8'h21);
    cover property (set_off[0] && reg_wr);
endmodule
bind ldoctl_regs ldoctl_chk ldoctl_chk_i (.core_clk, .sys_rst, .reg_wr, .reg_addr,
    .reg_wdata, .defaults_loaded, .otp_enable, .set_off, .ldo_on, .ldo_eco, .ldo_sel,
    .ldo_mv, .upper_sel, .upper_sel_eff, .upper_mv);

/* File: ldoctl_regs_test.sv */
// self-checking bench for the regulator control bank
`timescale 1ns/1ns
module ldoctl_regs_test;
    reg core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    reg [7:0] reg_addr = 0, reg_wdata = 0;
    reg [3:0] otp_enable = 0, set_off = 0;
    reg [23:0] otp_sel = 0;
    reg [5:0] upper_sel = 0;
    reg [7:0] ctl [0:3];
    wire [7:0] reg_rdata;
    wire reg_rvalid, defaults_loaded;
    wire [3:0] ldo_on, ldo_eco;
    wire [23:0] ldo_sel;
    wire [47:0] ldo_mv;
    wire [5:0] upper_sel_eff;
    wire [11:0] upper_mv;
    integer err_total = 0, checks = 0, cyc = 0, i, c, k;
    ldoctl_regs ldoctl_regs_i (.core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .otp_enable, .otp_sel, .defaults_loaded, .set_off, .ldo_on,
        .ldo_eco, .ldo_sel, .ldo_mv, .upper_sel, .upper_sel_eff, .upper_mv);
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            end_sim;
        end
    end
    function integer mv(input integer s);
        mv = s < 32 ? 800 + 25 * s : s < 61 ? 1600 + 50 * (s - 32) : 3100 + 100 * (s - 61);
    endfunction
    //////////////////////////////
    task chk(input [47:0] n, input [47:0] e, input [47:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %0s exp %h got %h", n, e, g);
            end
        end
    endtask
    task outs;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                chk("on", ctl[c][7] & ~set_off[c], ldo_on[c]);
                chk("eco", ctl[c][6], ldo_eco[c]);
                chk("sel", ctl[c][5:0], ldo_sel[c*6+:6]);
                chk("mv", mv(ctl[c][5:0]), ldo_mv[c*12+:12]);
            end
            chk("upsel", {1'b1, upper_sel[4:0]}, upper_sel_eff);
            chk("upmv", mv({1'b1, upper_sel[4:0]}), upper_mv);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d err_total %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        i = $urandom(30);
        for (k = 0; k < 2; k = k + 1) begin
            otp_enable = $urandom;
            otp_sel = $urandom;
            sys_rst = 1;
            repeat (10) @(negedge core_clk);
            chk("rst_on", 0, ldo_on);
            chk("rst_loaded", 0, defaults_loaded);
            chk("rst_rvalid", 0, reg_rvalid);
            sys_rst = 0;
            repeat (2) @(negedge core_clk);
            chk("loaded", 1, defaults_loaded);
            for (c = 0; c < 4; c = c + 1)
                ctl[c] = {otp_enable[c], 1'b0, otp_sel[c*6+:6]};
            outs;
            // every select code once; every fifth write lands on an unmapped offset
            for (i = 0; i < 64; i = i + 1) begin
                set_off = $urandom;
                upper_sel = $urandom;
                reg_addr = 8'h1e + i % 5;
                reg_wdata = $urandom * 64 + i;
                reg_wr = 1;
                if (i % 5 < 4)
                    ctl[i % 5] = reg_wdata;
                @(negedge core_clk);
                reg_wr = 0;
                @(negedge core_clk);
                chk("rvalid_idle", 0, reg_rvalid);
                outs;
                reg_rd = 1;
                @(negedge core_clk);
                reg_rd = 0;
                chk("rvalid", 1, reg_rvalid);
                chk("rdata", i % 5 < 4 ? ctl[i % 5] : 8'h00, reg_rdata);
            end
        end
        end_sim;
    end
endmodule
